// ===== rtl/pfr_load.sv
// pfr_load: three-wire serial word load, select decode, double buffering
// assumes host shifts msb first on rising sclk, then pulses latch high
// Summary of operation
// - select 0001 loads main fraction word
// - main fraction numerator is bits 27..4
// - select 0010 loads auxiliary modulus word
// - auxiliary modulus is bits 17..4
// - auxiliary modulus corrects residual fraction error
// - select 0011 loads auxiliary fraction word
// - auxiliary fraction numerator is bits 17..4
// - select 0100 loads register four
// - staged fields apply on word0 write
`default_nettype none
module pfr_load (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         resetn,
  // serial pins
  input  wire logic         ser_clk,
  input  wire logic         ser_data,
  input  wire logic         ser_latch,
  // effective fraction settings, raw word0/word4, load strobe and status flag
  output pfr_pkg::pfr_frac_t frac_active,
  output logic [31:0]       word0,
  output logic [31:0]       word4,
  output logic              word_strobe,
  output logic              aux_frac_ok
);
  logic clk_s;
  logic dat_s;
  logic le_s;
  // every pin passes two flops; pins must hold one period to be seen
  pfr_sync u_sclk (
    .ref_clk  (ref_clk),
    .resetn   (resetn),
    .pin_in   (ser_clk),
    .pin_sync (clk_s)
  );
  pfr_sync u_sdat (
    .ref_clk  (ref_clk),
    .resetn   (resetn),
    .pin_in   (ser_data),
    .pin_sync (dat_s)
  );
  pfr_sync u_sle (
    .ref_clk  (ref_clk),
    .resetn   (resetn),
    .pin_in   (ser_latch),
    .pin_sync (le_s)
  );

  logic                clk_d_r;
  logic                le_d_r;
  logic [31:0]         shift_r;
  logic [31:0]         shift_nxt;
  pfr_pkg::pfr_state_t state_r;
  pfr_pkg::pfr_state_t state_nxt;
  pfr_pkg::pfr_frac_t  stage_r;
  pfr_pkg::pfr_frac_t  stage_nxt;
  pfr_pkg::pfr_frac_t  active_r;
  pfr_pkg::pfr_frac_t  active_nxt;
  logic [31:0]         word0_r;
  logic [31:0]         word0_nxt;
  logic [31:0]         word4_r;
  logic [31:0]         word4_nxt;
  logic                strobe_r;
  logic                strobe_nxt;
  logic                ok_r;
  logic                ok_nxt;
  logic                rise;
  logic                latch_rise;
  logic [3:0]          sel;

  assign rise       = clk_s & ~clk_d_r;
  assign latch_rise = le_s & ~le_d_r;
  assign sel        = shift_r[pfr_pkg::SEL_W-1:0];

  always_comb begin
    state_nxt  = state_r;
    shift_nxt  = shift_r;
    stage_nxt  = stage_r;
    active_nxt = active_r;
    word0_nxt  = word0_r;
    word4_nxt  = word4_r;
    strobe_nxt = 1'b0;
    unique case (state_r)
      pfr_pkg::PFR_IDLE: begin
        if (rise) begin
          shift_nxt = {shift_r[30:0], dat_s};
          state_nxt = pfr_pkg::PFR_SHIFT;
        end
      end
      pfr_pkg::PFR_SHIFT: begin
        if (latch_rise) begin
          state_nxt = pfr_pkg::PFR_LATCH;
        end else if (rise) begin
          shift_nxt = {shift_r[30:0], dat_s};
        end
      end
      pfr_pkg::PFR_LATCH: begin
        state_nxt  = pfr_pkg::PFR_IDLE;
        strobe_nxt = 1'b1;
        // decode only the low nibble; upper bits are don't-care here
        unique case (sel)
          pfr_pkg::SEL_WORD0: begin
            word0_nxt  = shift_r;
            active_nxt = stage_r;
          end
          pfr_pkg::SEL_MAIN: begin
            stage_nxt.main_fraction_numerator =
              shift_r[pfr_pkg::MAIN_LSB +: pfr_pkg::MAIN_W];
          end
          pfr_pkg::SEL_AUX_MOD: begin
            stage_nxt.auxiliary_modulus = shift_r[pfr_pkg::AUX_LSB +: pfr_pkg::AUX_W];
          end
          pfr_pkg::SEL_AUX_FRAC: begin
            stage_nxt.auxiliary_fraction_numerator =
              shift_r[pfr_pkg::AUX_LSB +: pfr_pkg::AUX_W];
          end
          pfr_pkg::SEL_WORD4: begin
            word4_nxt = shift_r;
          end
          default: begin
          end
        endcase
      end
      default: state_nxt = pfr_pkg::PFR_IDLE;
    endcase
    // modulus feeds residual correction; flag if host broke the bound
    ok_nxt = active_nxt.auxiliary_fraction_numerator
             < active_nxt.auxiliary_modulus;
  end

  // registers only; edge detectors reset to the idle pin level, so no false edge
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      clk_d_r  <= 1'b0;
      le_d_r   <= 1'b0;
      state_r  <= pfr_pkg::PFR_IDLE;
      shift_r  <= pfr_pkg::WORD_RST;
      stage_r  <= '{pfr_pkg::MAIN_RST, pfr_pkg::AUX_MOD_RST, pfr_pkg::AUX_FRAC_RST};
      active_r <= '{pfr_pkg::MAIN_RST, pfr_pkg::AUX_MOD_RST, pfr_pkg::AUX_FRAC_RST};
      word0_r  <= pfr_pkg::WORD_RST;
      word4_r  <= pfr_pkg::WORD_RST;
      strobe_r <= 1'b0;
      ok_r     <= 1'b1;
    end else begin
      clk_d_r  <= clk_s;
      le_d_r   <= le_s;
      state_r  <= state_nxt;
      shift_r  <= shift_nxt;
      stage_r  <= stage_nxt;
      active_r <= active_nxt;
      word0_r  <= word0_nxt;
      word4_r  <= word4_nxt;
      strobe_r <= strobe_nxt;
      ok_r     <= ok_nxt;
    end
  end

  assign frac_active = active_r;
  assign word0       = word0_r;
  assign word4       = word4_r;
  assign word_strobe = strobe_r;
  assign aux_frac_ok = ok_r;

  // staged words reach the active set only through a word0 load
  hold_until_w0_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (state_r == pfr_pkg::PFR_LATCH && sel != pfr_pkg::SEL_WORD0)
    |=> $stable(active_r)) else $error("active fraction changed without word0");
  w0_applies_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (state_r == pfr_pkg::PFR_LATCH && sel == pfr_pkg::SEL_WORD0)
    |=> active_r == $past(stage_r)) else $error("word0 did not apply staged set");
  main_load_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (state_r == pfr_pkg::PFR_LATCH && sel == pfr_pkg::SEL_MAIN)
    |=> stage_r.main_fraction_numerator == $past(shift_r[27:4]))
    else $error("main fraction not staged");
  aux_mod_load_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (state_r == pfr_pkg::PFR_LATCH && sel == pfr_pkg::SEL_AUX_MOD)
    |=> stage_r.auxiliary_modulus == $past(shift_r[17:4]))
    else $error("aux modulus not staged");
  aux_frac_load_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (state_r == pfr_pkg::PFR_LATCH && sel == pfr_pkg::SEL_AUX_FRAC)
    |=> stage_r.auxiliary_fraction_numerator == $past(shift_r[17:4]))
    else $error("aux fraction not staged");
  word4_load_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (state_r == pfr_pkg::PFR_LATCH && sel == pfr_pkg::SEL_WORD4)
    |=> word4_r == $past(shift_r)) else $error("word4 not loaded");
  strobe_once_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    word_strobe |=> !word_strobe) else $error("strobe longer than one cycle");
  other_sel_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (state_r == pfr_pkg::PFR_LATCH && sel > pfr_pkg::SEL_WORD4)
    |=> $stable(stage_r) && $stable(word4_r) && $stable(word0_r))
    else $error("unselected word stored");

  // a latch edge seen mid-frame is decoded next cycle, then strobed once
  sequence latch_seen_s;
    state_r == pfr_pkg::PFR_SHIFT && latch_rise;
  endsequence
  sequence decode_then_strobe_s;
    (state_r == pfr_pkg::PFR_LATCH) ##1 (word_strobe && state_r == pfr_pkg::PFR_IDLE);
  endsequence
  latch_strobe_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    latch_seen_s |=> decode_then_strobe_s) else $error("latched word not decoded");

  // a serial clock edge with no latch edge, outside the decode cycle, pushes exactly one bit in
  sequence bit_taken_s;
    rise && !latch_rise && state_r != pfr_pkg::PFR_LATCH;
  endsequence
  shift_in_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    bit_taken_s |=> shift_r == {$past(shift_r[30:0]), $past(dat_s)})
    else $error("serial bit not shifted in");

  // a latch with no frame in progress must not reload a stale word
  sequence idle_latch_s;
    state_r == pfr_pkg::PFR_IDLE && latch_rise && !rise;
  endsequence
  idle_latch_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    idle_latch_s |=> state_r == pfr_pkg::PFR_IDLE && !word_strobe)
    else $error("latch without bits was decoded");

  // status flag tracks the active pair, never the staged one
  ok_flag_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    aux_frac_ok == (frac_active.auxiliary_fraction_numerator
                    < frac_active.auxiliary_modulus)) else $error("aux fraction flag wrong");
endmodule
`default_nettype wire

// ===== rtl/pfr_pkg.sv
// pfr_pkg: constants and types for the fraction register load block
// assumes a 32-bit programming word, control bits in the low nibble
`default_nettype none
package pfr_pkg;
  localparam int unsigned WORD_W   = 32;
  localparam int unsigned SEL_W    = 4;
  localparam int unsigned MAIN_W   = 24;
  localparam int unsigned MAIN_LSB = 4;
  localparam int unsigned AUX_W    = 14;
  localparam int unsigned AUX_LSB  = 4;
  localparam logic [3:0] SEL_WORD0    = 4'h0;
  localparam logic [3:0] SEL_MAIN     = 4'h1;
  localparam logic [3:0] SEL_AUX_MOD  = 4'h2;
  localparam logic [3:0] SEL_AUX_FRAC = 4'h3;
  localparam logic [3:0] SEL_WORD4    = 4'h4;
  localparam logic [23:0] MAIN_RST     = 24'h00_0000;
  localparam logic [13:0] AUX_MOD_RST  = 14'h0001;
  localparam logic [13:0] AUX_FRAC_RST = 14'h0000;
  localparam logic [31:0] WORD_RST  = 32'h0000_0000;

  typedef struct packed {
    logic [23:0] main_fraction_numerator;
    logic [13:0] auxiliary_modulus;
    logic [13:0] auxiliary_fraction_numerator;
  } pfr_frac_t;

  typedef enum logic [1:0] {
    PFR_IDLE  = 2'b00,
    PFR_SHIFT = 2'b01,
    PFR_LATCH = 2'b11
  } pfr_state_t;
endpackage
`default_nettype wire

// ===== rtl/pfr_sync.sv
// pfr_sync: two-flop synchroniser for one pin level
// assumes the pin is asynchronous to ref_clk
`default_nettype none
module pfr_sync (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic resetn,
  // level
  input  wire logic pin_in,
  output logic      pin_sync
);
  logic meta_r;
  logic sync_r;
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end else begin
      meta_r <= pin_in;
      sync_r <= meta_r;
    end
  end
  assign pin_sync = sync_r;
endmodule
`default_nettype wire

// ===== sim/pfr_host.sv
// pfr_host: host model driving the three-wire programming pins
// assumes ref_clk at 100 ns; serial clock period is 8 ref_clk cycles
`default_nettype none
module pfr_host (
  // reference clock
  input  wire logic ref_clk,
  // serial pins
  output logic      ser_clk,
  output logic      ser_data,
  output logic      ser_latch
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    ser_clk   = 1'b0;
    ser_data  = 1'b0;
    ser_latch = 1'b0;
  end
  // msb first; sclk stands low between frames
  task automatic send(input logic [31:0] w);
    for (int i = 31; i >= 0; i--) begin
      ser_data <= w[i];
      repeat (4) @(posedge ref_clk);
      ser_clk <= 1'b1;
      repeat (4) @(posedge ref_clk);
      ser_clk <= 1'b0;
    end
    // released data line shows the inverse, not a stale bit
    ser_data <= ~w[0];
    repeat (4) @(posedge ref_clk);
    ser_latch <= 1'b1;
    repeat (4) @(posedge ref_clk);
    ser_latch <= 1'b0;
  endtask
  // latch pulse with no frame before it; the block must ignore it
  task automatic latch_only();
    repeat (4) @(posedge ref_clk);
    ser_latch <= 1'b1;
    repeat (4) @(posedge ref_clk);
    ser_latch <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== sim/testbench.sv
// testbench: random fraction words through the serial host model
// assumes pfr_load answers within 8 cycles of the latch pulse
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic               ref_clk, resetn, ser_clk, ser_data, ser_latch;
  logic               word_strobe, aux_frac_ok;
  logic [31:0]        word0, word4, w;
  pfr_pkg::pfr_frac_t frac_active, exp_act, exp_stg;
  int                 fail_count, samples_checked;
  int                 strobes = 0;
  pfr_load i_dut (.ref_clk(ref_clk), .resetn(resetn), .ser_clk(ser_clk),
    .ser_data(ser_data), .ser_latch(ser_latch), .frac_active(frac_active),
    .word0(word0), .word4(word4), .word_strobe(word_strobe), .aux_frac_ok(aux_frac_ok));
  pfr_host i_host (.ref_clk(ref_clk), .ser_clk(ser_clk), .ser_data(ser_data),
    .ser_latch(ser_latch));
  always #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (word_strobe === 1'b1) strobes <= strobes + 1;
  task automatic check(input string what, input logic [63:0] e, input logic [63:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask
  // expected flag straight from the ordering rule, not from the block
  function automatic logic exp_ok(input pfr_pkg::pfr_frac_t a);
    return a.auxiliary_fraction_numerator < a.auxiliary_modulus;
  endfunction
  task automatic put(input logic [31:0] x);
    int n;
    n = strobes;
    i_host.send(x);
    repeat (8) @(posedge ref_clk);
    check("word_strobe count", n + 1, strobes);
  endtask
  task automatic verify();
    check("frac_active", exp_act, frac_active);
    check("aux_frac_ok", exp_ok(exp_act), aux_frac_ok);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    logic [23:0] f1;
    logic [13:0] m2, f2;
    int          n0;
    ref_clk = 1'b0;
    resetn = 1'b0;
    fail_count = 0;
    samples_checked = 0;
    void'($urandom(32'h4f73_1f1f));
    repeat (8) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge ref_clk);
    exp_act = {24'h00_0000, 14'h0001, 14'h0000};
    verify();
    // codes 5..15 each refused once, corners in round zero
    for (int r = 0; r < 11; r++) begin
      f1 = (r == 0) ? 24'hff_ffff : 24'($urandom);
      m2 = (r == 0) ? 14'h3fff : 14'($urandom) | 14'h0002;
      f2 = (r == 0) ? 14'h3ffe : 14'($urandom % m2);
      exp_stg = {f1, m2, f2};
      put({4'h0, f1, 4'h1});
      put({14'h0000, m2, 4'h2});
      put({14'h0000, f2, 4'h3});
      verify();
      w = {28'($urandom), 4'h4};
      put(w);
      check("word4", w, word4);
      w = {28'($urandom), 4'h0};
      put(w);
      exp_act = exp_stg;
      check("word0", w, word0);
      verify();
      put({28'($urandom), 4'(5 + r)});
      verify();
      check("word0 kept", w, word0);
      put(w);
      verify();
      $display("round %0d done", r);
    end
    // mid-run reset, then a latch pulse with no frame behind it
    resetn <= 1'b0;
    repeat (8) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge ref_clk);
    exp_act = {24'h00_0000, 14'h0001, 14'h0000};
    verify();
    check("word0 reset", 32'h0000_0000, word0);
    check("word4 reset", 32'h0000_0000, word4);
    n0 = strobes;
    i_host.latch_only();
    repeat (8) @(posedge ref_clk);
    check("idle latch strobes", n0, strobes);
    put(w);
    verify();
    $display("reset test done");
    wrap_up();
  end
endmodule
`default_nettype wire
